//--- mssr_status_regs.sv
// The APB interface to the registers was left to the implementer.
`include "mssr_consts.svh"
`default_nettype none
module mssr_status_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] output_voltage_magnitude,
    input wire logic [7:0] measured_resistance,
    input wire logic [7:0] measured_back_emf_constant,
    input wire logic [7:0] measured_inductance,
    input wire logic resistance_step_flag,
    input wire logic inductance_step_flag,
    input wire logic back_emf_step_flag,
    input wire logic mechanical_step_flag,
    input wire mssr_pkg::mssr_freq_code_type recommended_switching_freq
);

    ////////////////////////////////////////////////////////////////////////////
    // status capture from the measurement logic (same clock)
    mssr_pkg::mssr_word_type algorithm_status_q, algorithm_status_d;
    mssr_pkg::mssr_word_type measured_motor_parameters_q, measured_motor_parameters_d;
    mssr_pkg::mssr_word_type extraction_status_q, extraction_status_d;

    // algorithm status group
    always_comb begin
        algorithm_status_d = `MSSR_RESET_VALUE;
        algorithm_status_d[`MSSR_VOLTAGE_LSB +: 16] = output_voltage_magnitude;
    end

    // no bus term feeds these: writes cannot alter them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            algorithm_status_q <= `MSSR_RESET_VALUE;
        end else begin
            algorithm_status_q <= algorithm_status_d;
        end
    end

    // motor parameter group
    always_comb begin
        measured_motor_parameters_d = `MSSR_RESET_VALUE;
        measured_motor_parameters_d[`MSSR_RES_LSB +: 8] = measured_resistance;
        measured_motor_parameters_d[`MSSR_BEMF_LSB +: 8] = measured_back_emf_constant;
        measured_motor_parameters_d[`MSSR_IND_LSB +: 8] = measured_inductance;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            measured_motor_parameters_q <= `MSSR_RESET_VALUE;
        end else begin
            measured_motor_parameters_q <= measured_motor_parameters_d;
        end
    end

    // extraction status group
    always_comb begin
        extraction_status_d = `MSSR_RESET_VALUE;
        extraction_status_d[`MSSR_FLAG_RES_BIT] = resistance_step_flag;
        extraction_status_d[`MSSR_FLAG_IND_BIT] = inductance_step_flag;
        extraction_status_d[`MSSR_FLAG_BEMF_BIT] = back_emf_step_flag;
        extraction_status_d[`MSSR_FLAG_MECH_BIT] = mechanical_step_flag;
        extraction_status_d[`MSSR_FREQ_LSB +: 4] = recommended_switching_freq;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extraction_status_q <= `MSSR_RESET_VALUE;
        end else begin
            extraction_status_q <= extraction_status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    logic [31:0] prdata_q, prdata_d;
    logic setup;
    logic read_setup;
    logic hit_algorithm;
    logic hit_parameters;
    logic hit_extraction;
    logic hit_any;

    assign setup = psel && !penable;
    assign read_setup = setup && !pwrite;
    assign hit_algorithm = paddr == `MSSR_ADDR_ALGORITHM_STATUS;
    assign hit_parameters = paddr == `MSSR_ADDR_MOTOR_PARAMS;
    assign hit_extraction = paddr == `MSSR_ADDR_EXTRACTION_STATUS;
    assign hit_any = hit_algorithm || hit_parameters || hit_extraction;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_q;

    always_comb begin
        prdata_d = prdata_q;
        if (read_setup) begin
            unique case (paddr)
                `MSSR_ADDR_ALGORITHM_STATUS: prdata_d = algorithm_status_q;
                `MSSR_ADDR_MOTOR_PARAMS: prdata_d = measured_motor_parameters_q;
                `MSSR_ADDR_EXTRACTION_STATUS: prdata_d = extraction_status_q;
                default: prdata_d = `MSSR_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= `MSSR_RESET_VALUE;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_volt_field: assert property (
        setup && !pwrite && paddr == `MSSR_ADDR_ALGORITHM_STATUS
        |=> prdata[31:16] == $past(output_voltage_magnitude, 2))
        else $error("voltage magnitude field wrong");
    chk_volt_reserved: assert property (
        setup && !pwrite && paddr == `MSSR_ADDR_ALGORITHM_STATUS |=> prdata[15:0] == 16'h0000)
        else $error("algorithm status low half not zero");
    chk_res_field: assert property (
        setup && !pwrite && paddr == `MSSR_ADDR_MOTOR_PARAMS
        |=> prdata[31:24] == $past(measured_resistance, 2))
        else $error("resistance field wrong");
    chk_bemf_field: assert property (
        setup && !pwrite && paddr == `MSSR_ADDR_MOTOR_PARAMS
        |=> prdata[23:16] == $past(measured_back_emf_constant, 2))
        else $error("back emf field wrong");
    chk_ind_field: assert property (
        setup && !pwrite && paddr == `MSSR_ADDR_MOTOR_PARAMS
        |=> prdata[15:8] == $past(measured_inductance, 2) && prdata[7:0] == 8'h00)
        else $error("inductance field or reserved byte wrong");
    chk_flag_bits: assert property (
        setup && !pwrite && paddr == `MSSR_ADDR_EXTRACTION_STATUS
        |=> prdata[31] == $past(resistance_step_flag, 2)
            && prdata[28] == $past(mechanical_step_flag, 2))
        else $error("extraction flags wrong");
    chk_freq_code: assert property (
        setup && !pwrite && paddr == `MSSR_ADDR_EXTRACTION_STATUS
        |=> prdata[27:24] == $past(recommended_switching_freq, 2) && prdata[23:0] == 24'h0)
        else $error("frequency code wrong");
    chk_reset_zero: assert property (
        $rose(presetn) |-> prdata == 32'h0000_0000)
        else $error("read data not zero after reset");
    chk_write_ignored: assert property (
        setup && pwrite |=> $stable(prdata))
        else $error("write disturbed read data");
    chk_flag_middle: assert property (
        read_setup && hit_extraction
        |=> prdata[30] == $past(inductance_step_flag, 2)
            && prdata[29] == $past(back_emf_step_flag, 2))
        else $error("middle extraction flags wrong");
    chk_unmapped_zero: assert property (
        read_setup && !hit_any |=> prdata == `MSSR_UNMAPPED_READ)
        else $error("unmapped read not zero");
    chk_read_holds: assert property (
        !read_setup |=> $stable(prdata))
        else $error("read data changed without a read");
    chk_no_error: assert property (
        psel && penable |-> !pslverr && pready)
        else $error("transfer stalled or flagged an error");
    chk_mux_algorithm: assert property (
        read_setup && hit_algorithm |=> prdata == $past(algorithm_status_q))
        else $error("algorithm status read wrong");
    chk_mux_parameters: assert property (
        read_setup && hit_parameters |=> prdata == $past(measured_motor_parameters_q))
        else $error("motor parameter read wrong");
    chk_mux_extraction: assert property (
        read_setup && hit_extraction |=> prdata == $past(extraction_status_q))
        else $error("extraction status read wrong");

    // register capture checks
    chk_volt_capture: assert property (
        $past(presetn) |-> algorithm_status_q == {$past(output_voltage_magnitude), 16'h0000})
        else $error("voltage magnitude not captured");
    chk_params_capture: assert property (
        $past(presetn) |-> measured_motor_parameters_q == {$past(measured_resistance),
            $past(measured_back_emf_constant), $past(measured_inductance), 8'h00})
        else $error("motor parameters not captured");
    chk_flag_capture: assert property (
        $past(presetn) |-> extraction_status_q[31:28] == {$past(resistance_step_flag),
            $past(inductance_step_flag), $past(back_emf_step_flag),
            $past(mechanical_step_flag)})
        else $error("extraction flags not captured");
    chk_freq_capture: assert property (
        $past(presetn) |-> extraction_status_q[27:24] == $past(recommended_switching_freq)
            && extraction_status_q[23:0] == 24'h000000)
        else $error("frequency code not captured");
    chk_reset_clears: assert property (
        $rose(presetn) |-> algorithm_status_q == `MSSR_RESET_VALUE
            && measured_motor_parameters_q == `MSSR_RESET_VALUE
            && extraction_status_q == `MSSR_RESET_VALUE)
        else $error("status registers not zero after reset");

    cov_read_algo: cover property (setup && !pwrite && paddr == `MSSR_ADDR_ALGORITHM_STATUS);
    cov_read_params: cover property (setup && !pwrite && paddr == `MSSR_ADDR_MOTOR_PARAMS);
    cov_read_extr: cover property (setup && !pwrite && paddr == `MSSR_ADDR_EXTRACTION_STATUS);
    cov_write: cover property (setup && pwrite);
    cov_full_scale: cover property (algorithm_status_q[31:16] == `MSSR_VOLT_FULL_SCALE);

endmodule : mssr_status_regs
`default_nettype wire

//--- mssr_consts.svh
`ifndef MSSR_CONSTS_SVH
`define MSSR_CONSTS_SVH

// register indices (not all multiples of four)
`define MSSR_IDX_ALGORITHM_STATUS 8'he4
`define MSSR_IDX_MOTOR_PARAMS 8'he6
`define MSSR_IDX_EXTRACTION_STATUS 8'he8

// byte addresses are four times the index
`define MSSR_ADDR_ALGORITHM_STATUS 10'h390
`define MSSR_ADDR_MOTOR_PARAMS 10'h398
`define MSSR_ADDR_EXTRACTION_STATUS 10'h3a0

// field positions
`define MSSR_VOLTAGE_LSB 16
`define MSSR_RES_LSB 24
`define MSSR_BEMF_LSB 16
`define MSSR_IND_LSB 8
`define MSSR_FLAG_RES_BIT 31
`define MSSR_FLAG_IND_BIT 30
`define MSSR_FLAG_BEMF_BIT 29
`define MSSR_FLAG_MECH_BIT 28
`define MSSR_FREQ_LSB 24

// full scale of voltage magnitude (100 percent)
`define MSSR_VOLT_FULL_SCALE 16'h7fff

`define MSSR_RESET_VALUE 32'h0000_0000
`define MSSR_UNMAPPED_READ 32'h0000_0000

`endif

//--- mssr_pkg.sv
`default_nettype none
package mssr_pkg;
    typedef logic [31:0] mssr_word_type;
    typedef logic [3:0] mssr_freq_code_type;
endpackage : mssr_pkg
`default_nettype wire

//--- motor_system_status_regs_tb.sv
`default_nettype none
module motor_system_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic [15:0] volt = 16'h0000;
    logic [7:0] res = 8'h00;
    logic [7:0] bemf = 8'h00;
    logic [7:0] ind = 8'h00;
    logic [3:0] flags = 4'h0;
    mssr_pkg::mssr_freq_code_type freq = 4'h0;
    int bad_count = 0;
    int comparisons = 0;
    `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
        $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
    always #12.5 pclk = ~pclk;
    mssr_status_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .output_voltage_magnitude(volt),
        .measured_resistance(res), .measured_back_emf_constant(bemf),
        .measured_inductance(ind), .resistance_step_flag(flags[3]),
        .inductance_step_flag(flags[2]), .back_emf_step_flag(flags[1]),
        .mechanical_step_flag(flags[0]), .recommended_switching_freq(freq));
    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("counts: %0d compared, %0d wrong", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // one apb transfer, read data left in rd
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        `CHK(pslverr, 1'b0)
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            final_report();
        end
    endtask : apb
    // drive status inputs, read all, write all, read again
    task check_all(input logic [15:0] v, input logic [7:0] r, k, l, input logic [3:0] f, q);
        @(posedge pclk);
        {volt, res, bemf, ind, flags, freq} <= {v, r, k, l, f, q};
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, 10'h390, 32'h0000_0000);
            `CHK(rd, {v, 16'h0000})
            apb(1'b0, 10'h398, 32'h0000_0000);
            `CHK(rd, {r, k, l, 8'h00})
            apb(1'b0, 10'h3a0, 32'h0000_0000);
            `CHK(rd, {f, q, 24'h000000})
            for (int j = 0; j < 3; j++) begin
                apb(1'b1, 10'h390 + 10'(8 * j), 32'hffff_ffff);
            end
        end
        apb(1'b0, 10'h394, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
    endtask : check_all
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 10'h390 + 10'(8 * i), 32'h0000_0000);
            `CHK(rd, 32'h0000_0000)
        end
        $display("test reset values done");
        check_all(16'h7fff, 8'ha5, 8'h3c, 8'hc3, 4'b1010, 4'h9);
        $display("test pattern one done");
        check_all(16'h8001, 8'h5a, 8'hc3, 8'h3c, 4'b0101, 4'h6);
        $display("test pattern two done");
        final_report();
    end
endmodule : motor_system_status_regs_tb
`default_nettype wire
